/* bench/nand_host_model.sv */
// Host controller model driving serial mode 0 command frames
`timescale 1ns/100ps
module nand_host_model (
  output logic      spi_clk_out,
  output logic      cs_n_out,
  output logic      si_out,
  input  wire logic so_in
);
  // Link clock stands low and chip select high between frames
  initial begin
    spi_clk_out = 1'b0;
    cs_n_out    = 1'b1;
    si_out      = 1'b0;
  end
  // Sends nb bytes, most significant first, from the low end of tx; rx keeps the last byte read back
  task automatic frame(input logic [39:0] tx, input int nb, output logic [7:0] rx);
    #7 cs_n_out = 1'b0;
    for (int i = 8 * nb - 1; i >= 0; i--) begin
      si_out = tx[i];
      #80 spi_clk_out = 1'b1;
      rx = {rx[6:0], so_in};
      #80 spi_clk_out = 1'b0;
    end
    si_out   = ~si_out; // Stale data bit must not look valid
    cs_n_out = 1'b1;
    #320;
  endtask
endmodule // nand_host_model

/* bench/nand_sec_status_checker.sv */
// Pin-level checks of the security and status block
`timescale 1ns/100ps
module nand_sec_status_checker (
  input  wire logic        sys_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        spi_clk_in,
  input  wire logic        cs_n_in,
  input  wire logic        so_out,
  input  wire logic        so_oe_n_out,
  input  wire logic        otp_area_out,
  input  wire logic [16:0] array_row_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  // Clocks since chip select went high; commands act a few clocks after it because of the synchronisers
  logic [3:0] high_cnt;
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) high_cnt <= 4'h0;
    else if (!cs_n_in) high_cnt <= 4'h0;
    else if (high_cnt != 4'hF) high_cnt <= high_cnt + 4'h1;
  end
  // Frame phases seen on the raw pins
  sequence s_deselected; cs_n_in [*5]; endsequence
  sequence s_selected; (!cs_n_in) [*6]; endsequence
  sequence s_sck_high_drive; (spi_clk_in && !so_oe_n_out) [*4]; endsequence
  property p_oe_release; s_deselected |-> so_oe_n_out; endproperty
  property p_oe_fall; $fell(so_oe_n_out) |-> !cs_n_in; endproperty
  property p_oe_window; !so_oe_n_out |-> high_cnt <= 4'h4; endproperty
  property p_so_steady; s_sck_high_drive |-> $stable(so_out); endproperty
  property p_otp_rise; $rose(otp_area_out) |-> high_cnt inside {[4'h1:4'h8]}; endproperty
  property p_otp_steady; s_selected |-> $stable(otp_area_out); endproperty
  property p_row_steady; s_selected |-> $stable(array_row_out); endproperty
  property p_reset_clean; $rose(arst_n_in) |-> so_oe_n_out && !otp_area_out && array_row_out == 17'h00000; endproperty
  a_oe_release: assert property (p_oe_release) else $error("output enable held after deselect");
  a_oe_fall: assert property (p_oe_fall) else $error("output enable fell while deselected");
  a_oe_window: assert property (p_oe_window) else $error("output driven long after deselect");
  a_so_steady: assert property (p_so_steady) else $error("serial output moved while clock high");
  a_otp_rise: assert property (p_otp_rise) else $error("area select rose outside a command end");
  a_otp_steady: assert property (p_otp_steady) else $error("area select moved inside a frame");
  a_row_steady: assert property (p_row_steady) else $error("row moved inside a frame");
  a_reset_clean: assert property (p_reset_clean) else $error("outputs not idle after reset");
endmodule // nand_sec_status_checker

/* bench/nand_sec_status_tb_top.sv */
// Self-checking bench of the security and status block
`timescale 1ns/100ps
module nand_sec_status_tb_top;
  typedef struct {logic [39:0] tx; int nb; logic [7:0] mask; logic [7:0] exp;} row_t;
  logic        sys_clk, arst_n, ce, spi_clk, cs_n, si, so, so_oe_n, array_fail, otp_area;
  logic [2:0]  ecc_result;
  logic [7:0]  array_data, rx, op;
  logic [16:0] array_row;
  int          num_errors = 0;
  int          checked = 0;
  // Frame, then status mask and value expected (read frames compare their own data)
  row_t rows [31] = '{'{40'h06,1,8'hFF,8'h02}, '{40'h04,1,8'hFF,8'h00},
    '{40'h06,1,8'h00,8'h00}, '{40'h2C000B00,4,8'hFF,8'h00}, '{40'h06,1,8'h00,8'h00},
    '{40'h2C000C00,4,8'hFF,8'h0C}, '{40'h2C000000,4,8'hFF,8'h0C},
    '{40'h1FC0FF,3,8'hFF,8'h0C}, '{40'hFF,1,8'hFF,8'h00}, '{40'h1FB0C2,3,8'h00,8'h00},
    '{40'h06,1,8'h00,8'h00}, '{40'h10000000,4,8'hFF,8'h00}, '{40'h06,1,8'h00,8'h00},
    '{40'h2C000100,4,8'hFF,8'h02}, '{40'h1FB050,3,8'h00,8'h00}, '{40'h0FB000,3,8'hFF,8'h50},
    '{40'h06,1,8'h00,8'h00}, '{40'h10000002,4,8'hFF,8'h00}, '{40'h06,1,8'h00,8'h00},
    '{40'h1000000C,4,8'h08,8'h08}, '{40'h1FB0C0,3,8'h00,8'h00}, '{40'h06,1,8'h00,8'h00},
    '{40'h10000000,4,8'hFF,8'h00}, '{40'h13000000,4,8'h01,8'h00},
    '{40'h0300000000,5,8'hFF,8'h00}, '{40'h1FB050,3,8'h00,8'h00}, '{40'h06,1,8'h00,8'h00},
    '{40'h10000003,4,8'h08,8'h08}, '{40'hFF,1,8'h00,8'h00}, '{40'h0FB000,3,8'hFF,8'h10},
    '{40'h0300000000,5,8'hFF,8'h5A}};
  nand_sec_status #(.PROGRAM_CYCLES(20), .READ_CYCLES(2000), .ERASE_CYCLES(30), .RESET_CYCLES(10),
    .INIT_CYCLES(10)) dut (.sys_clk_in(sys_clk), .arst_n_in(arst_n), .ce_in(ce), .spi_clk_in(spi_clk),
    .cs_n_in(cs_n), .si_in(si), .so_out(so), .so_oe_n_out(so_oe_n), .ecc_result_in(ecc_result),
    .array_data_in(array_data), .array_fail_in(array_fail), .otp_area_out(otp_area), .array_row_out(array_row));
  nand_host_model host (.spi_clk_out(spi_clk), .cs_n_out(cs_n), .si_out(si), .so_in(so));
  task automatic check(input logic [16:0] seen, input logic [16:0] want);
    checked++;
    if (seen !== want) begin
      num_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // Poll status until the device is idle, bounded so a stuck busy flag cannot hang the run
  task automatic settle(output logic [7:0] st);
    st = 8'h01;
    for (int k = 0; k < 40 && st[0] !== 1'b0; k++) host.frame(40'h0FC000, 3, st);
    check(st[0], 1'b0);
  endtask
  task automatic test_done();
    $display("Checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Watchdog: about three times the expected run of some 16000 clocks
  initial begin
    repeat (50000) @(posedge sys_clk);
    num_errors++;
    test_done();
  end
  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    ecc_result = 3'h0;
    array_data = 8'h5A;
    array_fail = 1'b0;
    repeat (6) @(posedge sys_clk);
    check(so_oe_n, 1'b1);
    #2 arst_n = 1'b1;
    settle(rx);
    check(rx, 8'h00);
    foreach (rows[i]) begin
      host.frame(rows[i].tx, rows[i].nb, rx);
      op = 8'(rows[i].tx >> (8 * rows[i].nb - 8));
      if (rows[i].mask !== 8'h00 && op !== 8'h0F && op !== 8'h03) settle(rx);
      if (rows[i].mask !== 8'h00) check(rx & rows[i].mask, rows[i].exp);
    end
    check(otp_area, 1'b0);
    // A page read loads the row at issue and stays busy for the array time, then loads the ECC result
    @(posedge sys_clk);
    #2 ecc_result = 3'h3;
    host.frame(40'h13034567, 4, rx);
    host.frame(40'h0FC000, 3, rx);
    check(rx & 8'h01, 8'h01);
    settle(rx);
    check(rx & 8'h70, 8'h30);
    check(array_row, 17'h14567);
    // Random cache read raises both busy flags; a reset cuts it short
    host.frame(40'h30000000, 4, rx);
    host.frame(40'h0FC000, 3, rx);
    check(rx & 8'h81, 8'h81);
    host.frame(40'hFF, 1, rx);
    settle(rx);
    check(rx & 8'h81, 8'h00);
    // Programming into a permanently protected group must fail
    host.frame(40'h06, 1, rx);
    host.frame(40'h10000B05, 4, rx);
    settle(rx);
    check(rx & 8'h08, 8'h08);
    // Clock enable low freezes the device: a write disable sent meanwhile is lost
    @(posedge sys_clk);
    #2 ce = 1'b0;
    host.frame(40'h04, 1, rx);
    @(posedge sys_clk);
    #2 ce = 1'b1;
    host.frame(40'h1FB050, 3, rx);
    check(otp_area, 1'b1);
    host.frame(40'h0FC000, 3, rx);
    check(rx & 8'h02, 8'h02);
    test_done();
  end
endmodule // nand_sec_status_tb_top
bind nand_sec_status nand_sec_status_checker chk (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
  .spi_clk_in(spi_clk_in), .cs_n_in(cs_n_in), .so_out(so_out), .so_oe_n_out(so_oe_n_out),
  .otp_area_out(otp_area_out), .array_row_out(array_row_out));

/* verilog/nand_link_sampler.sv */
// Synchroniser and edge finder for the serial link pins
`timescale 1ns/100ps
module nand_link_sampler (
  input  wire logic sys_clk_in,
  input  wire logic arst_n_in,
  input  wire logic ce_in,
  input  wire logic spi_clk_in,
  input  wire logic cs_n_in,
  input  wire logic si_in,
  output logic      sck_rise_out,
  output logic      sck_fall_out,
  output logic      selected_out,
  output logic      si_out
);
  logic [1:0] clk_sync;
  logic [1:0] cs_n_sync;
  logic [1:0] si_sync;
  logic       clk_last;

  // Two stages per pin; edges are found only from the second stage onward
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      clk_sync  <= 2'h0;
      cs_n_sync <= 2'h3;
      si_sync   <= 2'h0;
      clk_last  <= 1'b0;
    end else if (ce_in) begin
      clk_sync  <= {clk_sync[0], spi_clk_in};
      cs_n_sync <= {cs_n_sync[0], cs_n_in};
      si_sync   <= {si_sync[0], si_in};
      clk_last  <= clk_sync[1];
    end
  end

  assign sck_rise_out = ce_in & clk_sync[1] & ~clk_last;
  assign sck_fall_out = ce_in & ~clk_sync[1] & clk_last;
  assign selected_out = ~cs_n_sync[1];
  assign si_out       = si_sync[1];
endmodule // nand_link_sampler

/* verilog/nand_sec_pkg.sv */
// Constants and types shared by the security and status logic of the serial NAND device
// Behaviour
// - Protect opcode takes three address bytes; row is the low 17 bits.
// - Row bits 11:8 pick one of twelve four-block groups, codes 0 to 11.
// - After program time the group is locked; status 0Ch on failure, 00h on success.
// - Mode 111, write enable, execute at row 0 disables protect for good.
// - Ten OTP pages of 2176 bytes exist and can never be erased.
// - Config data 50h or 40h enters OTP mode; array accesses go to OTP.
// - Query modes return all ones when disabled, all zeros when enabled.
// - Mode 110, write enable, execute at row 0 locks OTP programming.
// - Mode field: 000 normal, 010 OTP, 110 OTP lock, 111 protect disable.
// - Status is read at feature C0h and no feature write changes it.
// - Latch set by 06h, cleared by 04h or successful program or erase.
// - Cache-busy holds during random cache read; reset halts it.
// - ECC status clears on reset or read start, updates on read done.
// - Program-fail sets on failure or protected target, clears on execute or reset.
// - Erase-fail sets on failure or locked target, clears on erase start or reset.
// - Busy bit is high during every array operation, reset and power-up.
// - Reset returns the mode field to 000.
// - Protect is ignored unless write enable came immediately before it.
package nand_sec_pkg;
  // Opcodes
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_SET_FEATURE   = 8'h1F;
  localparam logic [7:0] OP_GET_FEATURE   = 8'h0F;
  localparam logic [7:0] OP_PROTECT       = 8'h2C;
  localparam logic [7:0] OP_PROG_EXECUTE  = 8'h10;
  localparam logic [7:0] OP_PAGE_READ     = 8'h13;
  localparam logic [7:0] OP_CACHE_RANDOM  = 8'h30;
  localparam logic [7:0] OP_BLOCK_ERASE   = 8'hD8;
  localparam logic [7:0] OP_READ_CACHE    = 8'h03;
  localparam logic [7:0] OP_RESET         = 8'hFF;
  // Feature addresses
  localparam logic [7:0] FEAT_CONFIG = 8'hB0;
  localparam logic [7:0] FEAT_STATUS = 8'hC0;
  // Security mode field codes
  localparam logic [2:0] MODE_NORMAL       = 3'h0;
  localparam logic [2:0] MODE_OTP          = 3'h2;
  localparam logic [2:0] MODE_OTP_LOCK     = 3'h6;
  localparam logic [2:0] MODE_PERM_DISABLE = 3'h7;
  // Configuration byte positions
  localparam int CF_MODE2  = 7;
  localparam int CF_MODE1  = 6;
  localparam int CF_LOT    = 5;
  localparam int CF_ECC_EN = 4;
  localparam int CF_MODE0  = 1;
  localparam logic ECC_EN_RESET = 1'b1;
  // Byte counts that complete a command frame
  localparam logic [2:0] BYTES_SHORT   = 3'h1;
  localparam logic [2:0] BYTES_FEATURE = 3'h3;
  localparam logic [2:0] BYTES_ADDR    = 3'h4;
  localparam logic [2:0] BYTES_CACHE   = 3'h3;
  // Row layout
  localparam int ROW_BITS    = 17;
  localparam int BLOCK_LSB   = 6;
  localparam int GROUP_LSB   = 8;
  localparam int GROUP_COUNT = 12;
  localparam logic [3:0] GROUP_LAST  = 4'hB;
  localparam logic [10:0] PROT_BLOCK_LIMIT = 11'h030;
  localparam logic [7:0] OTP_FIRST = 8'h02;
  localparam logic [7:0] OTP_LAST  = 8'h0B;
  localparam int OTP_SLOTS = 12;
  localparam logic [7:0] QUERY_ENABLED  = 8'h00;
  localparam logic [7:0] QUERY_DISABLED = 8'hFF;
  // Timing
  localparam int CLK_PERIOD_NS    = 20;
  localparam int PROGRAM_TIME_NS  = 200000;
  localparam int READ_TIME_NS     = 80000;
  localparam int ERASE_TIME_NS    = 2000000;
  localparam int RESET_TIME_NS    = 5000;
  localparam int INIT_TIME_NS     = 10000;
  localparam int PROGRAM_CYCLES   = (PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYCLES      = (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES     = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CYCLES     = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_CYCLES      = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_BITS       = 17;

  typedef enum logic [2:0] {
    OP_IDLE, OP_INIT, OP_PROGRAM, OP_PROTECTING, OP_ERASE, OP_READ, OP_RANDOM, OP_RESETTING
  } op_state_t;
endpackage

/* verilog/nand_sec_status.sv */
// Command decoder, status register and permanent/OTP protection of the serial NAND device
`timescale 1ns/100ps
module nand_sec_status #(
  parameter int PROGRAM_CYCLES = nand_sec_pkg::PROGRAM_CYCLES,
  parameter int READ_CYCLES    = nand_sec_pkg::READ_CYCLES,
  parameter int ERASE_CYCLES   = nand_sec_pkg::ERASE_CYCLES,
  parameter int RESET_CYCLES   = nand_sec_pkg::RESET_CYCLES,
  parameter int INIT_CYCLES    = nand_sec_pkg::INIT_CYCLES
) (
  input  wire logic        sys_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        ce_in,
  input  wire logic        spi_clk_in,
  input  wire logic        cs_n_in,
  input  wire logic        si_in,
  output logic             so_out,
  output logic             so_oe_n_out,
  input  wire logic [2:0]  ecc_result_in,
  input  wire logic [7:0]  array_data_in,
  input  wire logic        array_fail_in,
  output logic             otp_area_out,
  output logic [16:0]      array_row_out
);
  localparam int TW = nand_sec_pkg::TIMER_BITS;

  initial begin
    if (PROGRAM_CYCLES < 1 || READ_CYCLES < 1 || ERASE_CYCLES < 1 || RESET_CYCLES < 1 || INIT_CYCLES < 1 ||
        PROGRAM_CYCLES >= 2**TW || READ_CYCLES >= 2**TW || ERASE_CYCLES >= 2**TW ||
        RESET_CYCLES >= 2**TW || INIT_CYCLES >= 2**TW)
      $error("nand_sec_status: cycle counts must lie between 1 and the timer range");
  end

  // Decide whether a row falls in a permanently protected group
  function automatic logic group_locked(input logic [16:0] row, input logic [11:0] groups);
    logic [10:0] blk;
    blk = row[16:nand_sec_pkg::BLOCK_LSB];
    group_locked = (blk < nand_sec_pkg::PROT_BLOCK_LIMIT) && groups[blk[5:2]];
  endfunction

  logic       sck_rise;
  logic       sck_fall;
  logic       sel;
  logic       si_s;
  logic       sel_q;
  logic [2:0] bit_cnt;
  logic [2:0] byte_cnt;
  logic [6:0] shift_in;
  logic [7:0] cmd;
  logic [23:0] addr;
  logic [7:0] feat_sel;
  logic [7:0] tx;
  logic       out_bit;
  logic       out_en;
  logic       wren_last;
  nand_sec_pkg::op_state_t op_state;
  logic [TW-1:0] timer;
  logic [2:0] op_mode;
  logic [16:0] op_row;
  logic       pend_fail;
  logic       write_enable_latch;
  logic       pfail;
  logic       efail;
  logic       cache_read_busy;
  logic [2:0] ecc;
  logic [2:0] mode;
  logic       ecc_en;
  logic       lot_en;
  logic [11:0] prot_groups;
  logic [11:0] otp_written;
  logic       otp_locked;
  logic       perm_dis;
  logic [7:0] cache_query;

  nand_link_sampler u_sampler (
    .sys_clk_in   (sys_clk_in),
    .arst_n_in    (arst_n_in),
    .ce_in        (ce_in),
    .spi_clk_in   (spi_clk_in),
    .cs_n_in      (cs_n_in),
    .si_in        (si_in),
    .sck_rise_out (sck_rise),
    .sck_fall_out (sck_fall),
    .selected_out (sel),
    .si_out       (si_s)
  );

  // Frame decoding
  wire [7:0]  new_byte  = {shift_in, si_s};
  wire        byte_done = sel & sck_rise & (bit_cnt == 3'h7);
  wire        cs_end    = ce_in & sel_q & ~sel;
  wire        idle      = (op_state == nand_sec_pkg::OP_IDLE);
  wire        busy      = ~idle;
  wire [16:0] row       = addr[16:0];  // Upper seven address bits are dummy
  wire        full_addr = (byte_cnt == nand_sec_pkg::BYTES_ADDR);
  wire        short_cmd = (byte_cnt == nand_sec_pkg::BYTES_SHORT);
  wire        done      = ce_in & busy & (timer == '0);

  // Commands take effect when chip select rises; only reset is honoured while busy
  wire ex_wren    = cs_end & idle & short_cmd & (cmd == nand_sec_pkg::OP_WRITE_ENABLE);
  wire ex_wrdi    = cs_end & idle & short_cmd & (cmd == nand_sec_pkg::OP_WRITE_DISABLE);
  wire ex_reset   = cs_end & short_cmd & (cmd == nand_sec_pkg::OP_RESET) &
                    (op_state != nand_sec_pkg::OP_RESETTING) & (op_state != nand_sec_pkg::OP_INIT);
  wire ex_setf    = cs_end & idle & (byte_cnt == nand_sec_pkg::BYTES_FEATURE) &
                    (cmd == nand_sec_pkg::OP_SET_FEATURE);
  wire ex_protect = cs_end & idle & full_addr & (cmd == nand_sec_pkg::OP_PROTECT) &
                    write_enable_latch & wren_last & ~perm_dis;
  wire ex_program = cs_end & idle & full_addr & (cmd == nand_sec_pkg::OP_PROG_EXECUTE) & write_enable_latch;
  wire ex_erase   = cs_end & idle & full_addr & (cmd == nand_sec_pkg::OP_BLOCK_ERASE) & write_enable_latch;
  wire ex_read    = cs_end & idle & full_addr & (cmd == nand_sec_pkg::OP_PAGE_READ);
  wire ex_random  = cs_end & idle & full_addr & (cmd == nand_sec_pkg::OP_CACHE_RANDOM);
  wire ex_config  = ex_setf & (addr[15:8] == nand_sec_pkg::FEAT_CONFIG);  // Writes to status are dropped
  wire any_start  = ex_protect | ex_program | ex_erase | ex_read | ex_random;

  // Outcome of each target check, taken when the command issues
  wire otp_page_ok = (row[16:8] == 9'h000) && (row[7:0] >= nand_sec_pkg::OTP_FIRST) &&
                     (row[7:0] <= nand_sec_pkg::OTP_LAST);
  wire otp_fail    = ~otp_page_ok | otp_locked | otp_written[row[3:0]];
  wire prog_fail   = (mode == nand_sec_pkg::MODE_NORMAL) ? group_locked(row, prot_groups) :
                     (mode == nand_sec_pkg::MODE_OTP) ? otp_fail :
                     (mode == nand_sec_pkg::MODE_OTP_LOCK || mode == nand_sec_pkg::MODE_PERM_DISABLE) ?
                     (row != 17'h00000) : 1'b1;
  wire prot_fail   = (row[11:nand_sec_pkg::GROUP_LSB] > nand_sec_pkg::GROUP_LAST);
  wire erase_fail  = (mode != nand_sec_pkg::MODE_NORMAL) | group_locked(row, prot_groups);  // OTP never erases
  wire next_fail   = ex_protect ? prot_fail : ex_program ? prog_fail : ex_erase ? erase_fail : 1'b0;

  wire [TW-1:0] next_load = (ex_program | ex_protect) ? TW'(PROGRAM_CYCLES) :
                            ex_erase ? TW'(ERASE_CYCLES) :
                            ex_reset ? TW'(RESET_CYCLES) : TW'(READ_CYCLES);

  wire [7:0] status_byte = {cache_read_busy, ecc, pfail, efail, write_enable_latch, busy};
  wire [7:0] config_byte = {mode[2], mode[1], lot_en, ecc_en, 2'h0, mode[0], 1'b0};
  wire [7:0] fsel        = (byte_cnt == 3'h1) ? new_byte : feat_sel;
  wire [7:0] feat_value  = (fsel == nand_sec_pkg::FEAT_STATUS) ? status_byte :
                           (fsel == nand_sec_pkg::FEAT_CONFIG) ? config_byte : 8'h00;
  wire       query_mode  = (mode == nand_sec_pkg::MODE_OTP_LOCK) | (mode == nand_sec_pkg::MODE_PERM_DISABLE);
  wire [7:0] cache_value = query_mode ? cache_query : array_data_in;
  wire       load_feat   = byte_done & (byte_cnt != 3'h0) & (cmd == nand_sec_pkg::OP_GET_FEATURE);
  wire       load_cache  = byte_done & (byte_cnt >= nand_sec_pkg::BYTES_CACHE) & (cmd == nand_sec_pkg::OP_READ_CACHE);
  wire       complete_ok = done & ~pend_fail & ~array_fail_in;
  wire       complete_bad = done & (pend_fail | array_fail_in);
  wire       is_prog     = (op_state == nand_sec_pkg::OP_PROGRAM);
  wire       is_prot     = (op_state == nand_sec_pkg::OP_PROTECTING);
  wire       is_erase    = (op_state == nand_sec_pkg::OP_ERASE);
  wire       ecc_load    = done & ~is_prog & ~is_prot & ~is_erase;

  // Serial receive: bit and byte counters, command and address capture
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sel_q    <= 1'b0;
      bit_cnt  <= 3'h0;
      byte_cnt <= 3'h0;
      shift_in <= 7'h00;
      cmd      <= 8'h00;
      addr     <= 24'h000000;
      feat_sel <= 8'h00;
    end else if (ce_in) begin
      sel_q <= sel;
      if (!sel) begin
        bit_cnt  <= 3'h0;
        byte_cnt <= 3'h0;
      end else if (sck_rise) begin
        bit_cnt  <= bit_cnt + 3'h1;
        shift_in <= new_byte[6:0];
        if (bit_cnt == 3'h7) begin
          if (byte_cnt != 3'h7) byte_cnt <= byte_cnt + 3'h1;
          if (byte_cnt == 3'h0) cmd <= new_byte;
          if (byte_cnt == 3'h1) feat_sel <= new_byte;
          if (byte_cnt != 3'h0 && byte_cnt <= 3'h3) addr <= {addr[15:0], new_byte};
        end
      end
    end
  end

  // Serial transmit: bytes load on the rising edge, bits leave on the falling edge
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx      <= 8'hFF;
      out_bit <= 1'b1;
      out_en  <= 1'b0;
    end else if (ce_in) begin
      if (!sel) begin
        out_en <= 1'b0;
      end else if (load_feat | load_cache) begin
        tx     <= load_feat ? feat_value : cache_value;
        out_en <= 1'b1;
      end else if (sck_fall && out_en) begin
        out_bit <= tx[7];
        tx      <= {tx[6:0], 1'b1};
      end
    end
  end

  assign so_out      = out_bit;
  assign so_oe_n_out = ~(out_en & sel);

  // The write-enable must be the very last command before a protect
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wren_last <= 1'b0;
    end else if (cs_end && byte_cnt != 3'h0) begin
      wren_last <= ex_wren;
    end
  end

  // Operation sequencer: a single countdown covers every busy period
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      op_state  <= nand_sec_pkg::OP_INIT;  // Power-up load counts as busy
      timer     <= TW'(INIT_CYCLES);
      op_mode   <= nand_sec_pkg::MODE_NORMAL;
      op_row    <= 17'h00000;
      pend_fail <= 1'b0;
    end else if (ce_in) begin
      if (ex_reset) begin
        op_state <= nand_sec_pkg::OP_RESETTING;  // Halts a running cache read
        timer    <= next_load;
        op_row   <= 17'h00000;
      end else if (any_start) begin
        op_state  <= ex_protect ? nand_sec_pkg::OP_PROTECTING : ex_program ? nand_sec_pkg::OP_PROGRAM :
                     ex_erase ? nand_sec_pkg::OP_ERASE : ex_read ? nand_sec_pkg::OP_READ : nand_sec_pkg::OP_RANDOM;
        timer     <= next_load;
        op_mode   <= mode;
        op_row    <= row;
        pend_fail <= next_fail;
      end else if (done) begin
        op_state <= nand_sec_pkg::OP_IDLE;
      end else if (busy) begin
        timer <= timer - TW'(1);
      end
    end
  end

  // Status flags; a set in the same cycle as a clear wins, except ecc, where a reset clear beats the load at a read end
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      write_enable_latch   <= 1'b0;
      pfail <= 1'b0;
      efail <= 1'b0;
      cache_read_busy <= 1'b0;
      ecc   <= 3'h0;
    end else if (ce_in) begin
      if (ex_wrdi || (complete_ok && (is_prog || is_prot || is_erase)) || (complete_bad && is_prot))
        write_enable_latch <= 1'b0;
      if (ex_wren) write_enable_latch <= 1'b1;
      if (ex_program || ex_reset) pfail <= 1'b0;
      if (complete_bad && (is_prog || is_prot)) pfail <= 1'b1;
      if (ex_erase || ex_reset) efail <= 1'b0;
      if (complete_bad && (is_erase || is_prot)) efail <= 1'b1;  // Protect failure reads 0Ch
      if (ex_random) cache_read_busy <= 1'b1;
      else if (ex_reset || done) cache_read_busy <= 1'b0;
      if (ex_reset || ex_read || ex_random) ecc <= 3'h0;
      else if (ecc_load) ecc <= ecc_en ? ecc_result_in : 3'h0;  // Reset and power-up load block 0 page 0
    end
  end

  // Feature configuration; only the mode field and otp_area_out are cleared by a reset command
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode         <= nand_sec_pkg::MODE_NORMAL;
      ecc_en       <= nand_sec_pkg::ECC_EN_RESET;
      lot_en       <= 1'b0;
      otp_area_out <= 1'b0;
    end else if (ce_in) begin
      if (ex_reset) begin
        mode         <= nand_sec_pkg::MODE_NORMAL;
        otp_area_out <= 1'b0;
      end else if (ex_config) begin
        mode   <= {addr[nand_sec_pkg::CF_MODE2], addr[nand_sec_pkg::CF_MODE1], addr[nand_sec_pkg::CF_MODE0]};
        ecc_en <= addr[nand_sec_pkg::CF_ECC_EN];
        lot_en <= addr[nand_sec_pkg::CF_LOT] | lot_en;  // Lock tight stays until power is removed
        otp_area_out <= ({addr[nand_sec_pkg::CF_MODE2], addr[nand_sec_pkg::CF_MODE1],
                          addr[nand_sec_pkg::CF_MODE0]} == nand_sec_pkg::MODE_OTP);
      end
    end
  end

  // Nonvolatile protection state; only the power-on reset stands in for factory state
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prot_groups <= 12'h000;
      otp_written <= 12'h000;
      otp_locked  <= 1'b0;
      perm_dis    <= 1'b0;
    end else if (complete_ok) begin
      if (is_prot)
        prot_groups[op_row[11:nand_sec_pkg::GROUP_LSB]] <= 1'b1;
      if (is_prog && op_mode == nand_sec_pkg::MODE_OTP)
        otp_written[op_row[3:0]] <= 1'b1;
      if (is_prog && op_mode == nand_sec_pkg::MODE_OTP_LOCK)
        otp_locked <= 1'b1;
      if (is_prog && op_mode == nand_sec_pkg::MODE_PERM_DISABLE)
        perm_dis <= 1'b1;
    end
  end

  // Query result placed in the cache by a page read in a lock-bit mode
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cache_query   <= nand_sec_pkg::QUERY_DISABLED;
      array_row_out <= 17'h00000;
    end else if (ce_in) begin
      array_row_out <= op_row;  // Array accesses follow otp_area_out while in OTP mode
      if (done && op_state == nand_sec_pkg::OP_READ) begin
        if (op_mode == nand_sec_pkg::MODE_OTP_LOCK)
          cache_query <= otp_locked ? nand_sec_pkg::QUERY_ENABLED : nand_sec_pkg::QUERY_DISABLED;
        else if (op_mode == nand_sec_pkg::MODE_PERM_DISABLE)
          cache_query <= perm_dis ? nand_sec_pkg::QUERY_ENABLED : nand_sec_pkg::QUERY_DISABLED;
      end
    end
  end
endmodule // nand_sec_status
